// File: rtl/acc_map.vh
`ifndef ACC_MAP_VH
`define ACC_MAP_VH
`define ACC_OFF_MODE 8'h10
`define ACC_OFF_CLKLOW 8'h11
`define ACC_OFF_HIGH 8'h12
`define ACC_OFF_VREF 8'h13
`define ACC_OFF_SAMPLE 8'h14
`define ACC_RST_MODE 8'h20
`define ACC_RST_CLKLOW 4'h0
`define ACC_RST_HIGH 8'h00
`define ACC_RST_VREF 3'h3
`define ACC_RST_SAMPLE 7'h0A
`define ACC_BIT_ON 7
`define ACC_BIT_START 6
`define ACC_BIT_DONE 5
`define ACC_BIT_GATE 4
`define ACC_BIT_FLAG 7
`define ACC_BIT_IE 6
`define ACC_SEL_QVDD 4'hB
`define ACC_SEL_GND 4'hC
`define ACC_RESP_OKAY 2'h0
`define ACC_RESP_SLVERR 2'h2
`endif

// File: rtl/acc_ctrl.v
// What this block does
// RULE_01: The converter is powered and enabled only while converter_on is one, which resets to zero.
// RULE_02: Writing one to the start bit begins a conversion, and the start bit always reads zero.
// RULE_03: conversion_done reads zero during a conversion and one once the result registers are valid.
// RULE_04: With channel_gate zero every input channel is disconnected; one lets the selected one through.
// RULE_05: input_select codes 0-4 pick port A pins 0-4, 5-10 port B pins 0-5, 11 quarter supply, 12 ground.
// RULE_06: conversion_flag is set at the end of a conversion and only a firmware write of zero clears it.
// RULE_07: The interrupt request is high only while conversion_irq_enable and conversion_flag are both one.
// RULE_08: conv_clock_div divides the instruction clock by 16, 8, 1 or 2 for codes 00, 01, 10, 11.
// RULE_09: Result bits 3 to 0 read as the low nibble of the clock, flag and low-result register.
// RULE_10: Result bits 11 to 4 read from a separate high-byte register that resets to zero.
// RULE_11: The upper reference is internal at the chosen level when external select is zero, else pin A0.
// RULE_12: internal_reference_level codes 11, 10, 01, 00 give supply, 4 V, 3 V and 2 V, resetting to 11.
// RULE_13: sample_width_select gives 1, 2, 4 or 8 converter clocks of sampling and resets to code 10.
// RULE_14: resolution_select gives 8 bits for 00, 10 bits for 01, 12 bits otherwise, resetting to 12 bits.
// RULE_15: An analog_only_pin bit of one makes port B pin 3, 4 or 5 a pure analog input.
// RULE_16: conversion_done falls the cycle after a start is taken and rises with the flag when latched.
// RULE_17: A conversion is one sampling pulse then one converter clock per bit, MSB-aligned.
`timescale 1ns/100ps
`default_nettype none
`include "acc_map.vh"
module acc_ctrl (
    input wire clk,
    input wire rst_n,
    input wire [6:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [6:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire comparator_high,
    output wire converter_power,
    output wire channel_connect,
    output wire [3:0] input_select,
    output wire external_reference_select,
    output wire [1:0] internal_reference_level,
    output wire [2:0] analog_only_pin,
    output wire sample_hold,
    output wire [11:0] trial_code,
    output wire conv_irq
);
    localparam ST_IDLE = 2'd0;
    localparam ST_SAMPLE = 2'd1;
    localparam ST_BITS = 2'd2;

    reg on_q, gate_q, done_q, flag_q, ie_q, extref_q;
    reg [3:0] sel_q;
    reg [1:0] div_q, vhs_q, shck_q, res_q;
    reg [2:0] aop_q;
    reg [11:0] result_q, sar_q;
    reg [1:0] state_q;
    reg [3:0] prediv_q;
    reg [2:0] scnt_q;
    reg [3:0] bit_q;
    reg aw_held_q, w_held_q;
    reg [6:0] aw_q;
    reg [7:0] wd_q;

    // Converter clock tick from the instruction clock.
    function [3:0] div_max;
        input [1:0] code;
        begin
            case (code)
                2'b00: div_max = 4'd15;
                2'b01: div_max = 4'd7;
                2'b10: div_max = 4'd0;
                default: div_max = 4'd1;
            endcase
        end
    endfunction

    // The register offsets are word indices, so the byte address is four times the offset.
    // Seven address bits are needed to reach index 0x14.
    function [7:0] reg_idx;
        input [6:0] addr;
        begin
            reg_idx = {3'b000, addr[6:2]};
        end
    endfunction

    // True only for the five register indices that this block answers.
    function is_mapped;
        input [7:0] idx;
        begin
            is_mapped = (idx >= `ACC_OFF_MODE) && (idx <= `ACC_OFF_SAMPLE);
        end
    endfunction

    wire adc_tick = (prediv_q >= div_max(div_q)); // RULE_08
    wire [2:0] samp_last = (3'd1 << shck_q) - 3'd1; // RULE_13
    wire [3:0] nbits = res_q[1] ? 4'd12 : (res_q[0] ? 4'd10 : 4'd8); // RULE_14

    // Write address and data are taken in either order, then answered together.
    assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
    assign s_axi_wready = !w_held_q && !s_axi_bvalid;
    wire aw_now = aw_held_q || (s_axi_awvalid && s_axi_awready);
    wire w_now = w_held_q || (s_axi_wvalid && s_axi_wready);
    wire [6:0] waddr = aw_held_q ? aw_q : s_axi_awaddr;
    wire [7:0] widx = reg_idx(waddr);
    wire [7:0] wbyte = w_held_q ? wd_q : s_axi_wdata[7:0];
    wire wlane = w_held_q ? 1'b1 : s_axi_wstrb[0];
    reg wlane_q;
    wire wr_go = aw_now && w_now;
    wire wr_en = wr_go && (w_held_q ? wlane_q : wlane);
    // A write with lane zero strobe clear is still answered, but changes nothing.
    wire wr_mode = wr_en && (widx == `ACC_OFF_MODE);
    wire wr_clk = wr_en && (widx == `ACC_OFF_CLKLOW);
    wire wr_vref = wr_en && (widx == `ACC_OFF_VREF);
    wire wr_samp = wr_en && (widx == `ACC_OFF_SAMPLE);
    wire start_req = wr_mode && wbyte[`ACC_BIT_START] && wbyte[`ACC_BIT_ON]; // RULE_02

    wire finish = (state_q == ST_BITS) && adc_tick && (bit_q == 4'd0);
    wire [3:0] cur_bit = 4'd11 - (nbits - 4'd1 - bit_q);
    reg [11:0] sar_next;
    always @* begin
        sar_next = sar_q;
        if (!comparator_high) begin
            sar_next[cur_bit] = 1'b0;
        end
        if (bit_q != 4'd0) begin
            sar_next[cur_bit - 4'd1] = 1'b1;
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            aw_q <= 7'h00;
            wd_q <= 8'h00;
            wlane_q <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `ACC_RESP_OKAY;
        end else begin
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (wr_go) begin
                aw_held_q <= 1'b0;
                w_held_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= is_mapped(widx) ? `ACC_RESP_OKAY : `ACC_RESP_SLVERR;
            end else begin
                if (s_axi_awvalid && s_axi_awready) begin
                    aw_held_q <= 1'b1;
                    aw_q <= s_axi_awaddr;
                end
                if (s_axi_wvalid && s_axi_wready) begin
                    w_held_q <= 1'b1;
                    wd_q <= s_axi_wdata[7:0];
                    wlane_q <= s_axi_wstrb[0];
                end
            end
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            on_q <= 1'b0;
            gate_q <= 1'b0;
            sel_q <= 4'h0;
            ie_q <= 1'b0;
            div_q <= 2'b00;
            extref_q <= 1'b0;
            vhs_q <= 2'b11;
            aop_q <= 3'h0;
            shck_q <= 2'b10;
            res_q <= 2'b10;
        end else begin
            if (wr_mode) begin
                on_q <= wbyte[`ACC_BIT_ON]; // RULE_01
                gate_q <= wbyte[`ACC_BIT_GATE];
                sel_q <= wbyte[3:0];
            end
            if (wr_clk) begin
                ie_q <= wbyte[`ACC_BIT_IE];
                div_q <= wbyte[5:4];
            end
            if (wr_vref) begin
                extref_q <= wbyte[7];
                vhs_q <= wbyte[1:0]; // RULE_12
            end
            if (wr_samp) begin
                aop_q <= wbyte[6:4];
                shck_q <= wbyte[3:2];
                res_q <= wbyte[1:0];
            end
        end
    end

    // Converter sequencer; dropping converter_on aborts and leaves the old result.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            prediv_q <= 4'h0;
            scnt_q <= 3'h0;
            bit_q <= 4'h0;
            sar_q <= 12'h000;
            result_q <= 12'h000; // RULE_10
            done_q <= 1'b1;
            flag_q <= 1'b0;
        end else begin
            prediv_q <= (state_q == ST_IDLE || adc_tick) ? 4'h0 : prediv_q + 4'h1;
            if (wr_clk && !wbyte[`ACC_BIT_FLAG]) begin
                flag_q <= 1'b0;
            end
            // A start that switches the converter on in the same write must not be lost
            // to the abort path, since on_q only rises at this very edge.
            if (!on_q && !start_req) begin
                state_q <= ST_IDLE;
                done_q <= 1'b1;
            end else begin
                case (state_q)
                    ST_IDLE: begin
                        if (start_req) begin
                            state_q <= ST_SAMPLE;
                            scnt_q <= 3'h0;
                            done_q <= 1'b0; // RULE_16
                        end
                    end
                    ST_SAMPLE: begin
                        if (adc_tick) begin
                            if (scnt_q == samp_last) begin
                                state_q <= ST_BITS; // RULE_17
                                bit_q <= nbits - 4'd1;
                                sar_q <= 12'h800;
                            end else begin
                                scnt_q <= scnt_q + 3'h1;
                            end
                        end
                    end
                    ST_BITS: begin
                        if (adc_tick) begin
                            sar_q <= sar_next;
                            bit_q <= bit_q - 4'd1;
                            if (finish) begin
                                state_q <= ST_IDLE;
                                result_q <= sar_next; // RULE_17
                                done_q <= 1'b1; // RULE_03
                                flag_q <= 1'b1; // RULE_06
                            end
                        end
                    end
                    default: state_q <= ST_IDLE;
                endcase
            end
        end
    end

    wire [7:0] ridx = reg_idx(s_axi_araddr);
    assign s_axi_arready = !s_axi_rvalid;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `ACC_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `ACC_RESP_OKAY;
            if (ridx == `ACC_OFF_MODE) begin
                s_axi_rdata <= {24'h000000, on_q, 1'b0, done_q, gate_q, sel_q}; // RULE_02
            end else if (ridx == `ACC_OFF_CLKLOW) begin
                s_axi_rdata <= {24'h000000, flag_q, ie_q, div_q, result_q[3:0]}; // RULE_09
            end else if (ridx == `ACC_OFF_HIGH) begin
                s_axi_rdata <= {24'h000000, result_q[11:4]}; // RULE_10
            end else if (ridx == `ACC_OFF_VREF) begin
                s_axi_rdata <= {24'h000000, extref_q, 5'h00, vhs_q};
            end else if (ridx == `ACC_OFF_SAMPLE) begin
                s_axi_rdata <= {24'h000000, 1'b0, aop_q, shck_q, res_q};
            end else begin
                s_axi_rdata <= 32'h0000_0000;
                s_axi_rresp <= `ACC_RESP_SLVERR;
            end
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    assign converter_power = on_q; // RULE_01
    assign channel_connect = on_q && gate_q && (sel_q <= `ACC_SEL_GND); // RULE_04
    assign input_select = sel_q; // RULE_05
    assign external_reference_select = extref_q; // RULE_11
    assign internal_reference_level = vhs_q; // RULE_12
    assign analog_only_pin = aop_q; // RULE_15
    assign sample_hold = (state_q == ST_SAMPLE);
    assign trial_code = sar_q;
    assign conv_irq = ie_q && flag_q; // RULE_07
endmodule
`default_nettype wire

// File: tb/acc_ctrl_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module acc_ctrl_checker (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic [31:0] s_axi_rdata,
    input wire logic converter_power,
    input wire logic channel_connect,
    input wire logic [3:0] input_select,
    input wire logic sample_hold,
    input wire logic conv_irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    chk_conn_power: assert property (channel_connect |-> converter_power)
        else $error("channel connected while converter off");
    chk_conn_select: assert property (channel_connect |-> input_select <= 4'hC)
        else $error("channel connected with reserved select code");
    chk_sample_power: assert property (sample_hold |-> converter_power)
        else $error("sampling while converter off");
    chk_sample_len: assert property (sample_hold |-> ##[1:129] !sample_hold)
        else $error("sampling pulse too long");
    chk_irq_sticky: assert property (conv_irq && !s_axi_awvalid && !s_axi_wvalid
        && !s_axi_bvalid |=> conv_irq)
        else $error("interrupt dropped without a write");
    chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |=> s_axi_bvalid)
        else $error("write response late");
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response late");
    chk_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
        else $error("upper read bits not zero");
endmodule
bind acc_ctrl acc_ctrl_checker u_chk (.clk, .rst_n, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rvalid, .s_axi_rdata, .converter_power, .channel_connect, .input_select,
    .sample_hold, .conv_irq);
`default_nettype wire

// File: tb/acc_adc_model.sv
`timescale 1ns/100ps
`default_nettype none
module acc_adc_model #(parameter logic [11:0] LEVEL = 12'hA57) (
    input wire logic converter_power,
    input wire logic channel_connect,
    input wire logic [11:0] trial_code,
    output logic comparator_high
);
    // An unpowered or disconnected core never reports a high comparison.
    assign comparator_high = converter_power && channel_connect && (LEVEL >= trial_code);
endmodule
`default_nettype wire

// File: tb/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
    localparam logic [6:0] A_MO = 7'h40, A_CL = 7'h44, A_HI = 7'h48;
    localparam logic [6:0] A_VR = 7'h4C, A_SA = 7'h50, A_BAD = 7'h54;
    logic clk, rst_n, awv, awr, wv, wr_, bv, bry, arv, arr, rv, rry;
    logic cmp, pwr, conn, ext, sh, irq;
    logic [6:0] awa, ara;
    logic [3:0] wst;
    logic [1:0] wresp;
    logic [31:0] wd, rdd;
    logic [1:0] br, rr, lvl;
    logic [3:0] isel;
    logic [2:0] apin;
    logic [11:0] trial;
    int n_fail, n_compared;
    int n_sh = 0;
    acc_ctrl dut (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(wst), .s_axi_wvalid(wv),
        .s_axi_wready(wr_), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdd),
        .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry), .comparator_high(cmp),
        .converter_power(pwr), .channel_connect(conn), .input_select(isel),
        .external_reference_select(ext), .internal_reference_level(lvl),
        .analog_only_pin(apin), .sample_hold(sh), .trial_code(trial), .conv_irq(irq));
    acc_adc_model u_adc (.converter_power(pwr), .channel_connect(conn),
        .trial_code(trial), .comparator_high(cmp));
    task summarize;
        $display("compared %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task chk(input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e) begin
            n_fail++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    // Ready is latched at the falling edge so the rising edge acts on a settled value.
    task wr(input logic [6:0] a, input logic [7:0] d);
        logic pa, pw, ta, tw;
        @(posedge clk);
        awa <= a;
        wd <= 32'(d);
        awv <= 1;
        wv <= 1;
        bry <= 1;
        pa = 1;
        pw = 1;
        while (pa || pw) begin
            @(negedge clk);
            ta = awr;
            tw = wr_;
            @(posedge clk);
            if (pa && ta) begin
                awv <= 0;
                pa = 0;
            end
            if (pw && tw) begin
                wv <= 0;
                pw = 0;
            end
        end
        do begin
            @(negedge clk);
            ta = bv;
            wresp = br;
            @(posedge clk);
        end while (ta !== 1'b1);
        bry <= 0;
    endtask
    task rd(input logic [6:0] a, output logic [31:0] d, output logic [1:0] r);
        logic t;
        @(posedge clk);
        ara <= a;
        arv <= 1;
        rry <= 1;
        do begin
            @(negedge clk);
            t = arr;
            @(posedge clk);
        end while (t !== 1'b1);
        arv <= 0;
        do begin
            @(negedge clk);
            t = rv;
            d = rdd;
            r = rr;
            @(posedge clk);
        end while (t !== 1'b1);
        rry <= 0;
    endtask
    task rchk(input logic [6:0] a, input logic [7:0] e);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        chk(d, 32'(e));
    endtask
    task t_reset;
        logic [31:0] d;
        logic [1:0] r;
        chk(32'(pwr), 0);
        rchk(A_MO, 8'h20);
        rchk(A_CL, 8'h00);
        rchk(A_HI, 8'h00);
        rchk(A_VR, 8'h03);
        rchk(A_SA, 8'h0A);
        rd(A_BAD, d, r);
        chk(32'(r), 2);
        chk(d, 0);
        wr(A_BAD, 8'hFF);
        chk(32'(wresp), 2);
    endtask
    task t_pins;
        wr(A_VR, 8'h80);
        chk(32'(ext), 1);
        chk(32'(wresp), 0);
        wst <= 4'h0;
        wr(A_VR, 8'h00);
        wst <= 4'hF;
        chk(32'(wresp), 0);
        chk(32'(ext), 1);
        wr(A_VR, 8'h01);
        chk(32'({ext, lvl}), 1);
        wr(A_SA, 8'h7A);
        chk(32'(apin), 7);
        rchk(A_SA, 8'h7A);
    endtask
    task t_conv(input logic [1:0] i);
        logic [11:0] e;
        logic [3:0] s;
        logic [31:0] d;
        logic [1:0] r;
        int k, w, b;
        e = (i == 0) ? 12'hA50 : (i == 1) ? 12'hA54 : 12'hA57;
        s = {2'b00, i} * 4'h3;
        w = (1 << i) * ((i == 0) ? 16 : (i == 1) ? 8 : (i == 2) ? 1 : 2);
        wr(A_SA, {4'h0, i, i});
        wr(A_CL, {1'b0, i[0], i, 4'h0});
        b = n_sh;
        wr(A_MO, {4'b1101, s});
        chk(32'({pwr, conn, isel}), 32'({2'b11, s}));
        rchk(A_MO, {4'b1001, s});
        for (k = 0; k < 100; k++) begin
            rd(A_MO, d, r);
            if (d[5] === 1'b1)
                break;
        end
        chk(d, 32'({4'b1011, s}));
        chk(n_sh - b, w);
        rchk(A_HI, e[11:4]);
        rchk(A_CL, {1'b1, i[0], i, e[3:0]});
        chk(32'(irq), 32'(i[0]));
        wr(A_CL, {1'b0, i[0], i, 4'h0});
        rchk(A_CL, {1'b0, i[0], i, e[3:0]});
        chk(32'(irq), 0);
    endtask
    always @(posedge clk) if (sh === 1'b1) n_sh <= n_sh + 1;
    initial begin
        clk = 0;
        forever #50 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        summarize;
    end
    initial begin
        {rst_n, awv, wv, bry, arv, rry, awa, ara, wd} = '0;
        wst = 4'hF;
        n_fail = 0;
        n_compared = 0;
        repeat (12) @(posedge clk);
        rst_n <= 1;
        t_reset;
        t_pins;
        for (int i = 0; i < 4; i++) t_conv(2'(i));
        summarize;
    end
endmodule
`default_nettype wire
